// File: lcdc_defines.svh
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH
// ----------------------------------------
// register codes (d7..d4 on write, read address on read)
// ----------------------------------------
`define LCDC_OFS_ROW_LO   4'h2
`define LCDC_OFS_ROW_HI   4'h3
`define LCDC_OFS_START_LO 4'h4
`define LCDC_OFS_START_HI 4'h5
`define LCDC_OFS_ALT_LO   4'h6
`define LCDC_OFS_ALT_HI   4'h7
`define LCDC_OFS_DISP1    4'h8
`define LCDC_OFS_DISP2    4'h9
// ----------------------------------------
// reset values
// ----------------------------------------
`define LCDC_RST_NIB      4'h0
`define LCDC_RST_LINE     6'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define LCDC_B_DISP_ON    0
`define LCDC_B_ALL_ON     1
`define LCDC_B_SEG_ON     2
`define LCDC_B_SHIFT      3
`define LCDC_B_IR         0
`define LCDC_B_ER         1
`define LCDC_B_REF        0
`define LCDC_B_SWAP       1
`define LCDC_B_LINE_ALTERNATION_ENABLE       2
`define LCDC_B_REV        3
// ----------------------------------------
// address limits
// ----------------------------------------
`define LCDC_ROW_ICON     7'h40
`define LCDC_COL_LAST     4'hf
`endif

// File: lcdc_pkg.sv
package lcdc_pkg;
	typedef logic [3:0] lcdc_nib_t;
	typedef logic [5:0] lcdc_line_t;
	typedef logic [6:0] lcdc_row_t;
	typedef logic [7:0] lcdc_byte_t;

	function automatic lcdc_byte_t lcdc_rev8(input lcdc_byte_t b);
		lcdc_byte_t r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7-i];
		end
		return r;
	endfunction
endpackage

// File: lcdc_map.sv
`include "lcdc_defines.svh"
module lcdc_map (
	// write path
	input  wire lcdc_pkg::lcdc_byte_t din,
	input  wire lcdc_pkg::lcdc_nib_t  col,
	input  wire lcdc_pkg::lcdc_row_t  row,
	input  wire logic                 mirror,
	input  wire logic                 swap,
	output lcdc_pkg::lcdc_byte_t      wdata,
	output lcdc_pkg::lcdc_nib_t       col_int,
	output logic                      icon_sel,
	// dot path
	input  wire logic                 pix,
	input  wire logic                 seg_pix,
	input  wire logic                 disp_on,
	input  wire logic                 all_on,
	input  wire logic                 invert,
	input  wire logic                 seg_on,
	output logic                      dot,
	output logic                      seg
);
	import lcdc_pkg::*;
	logic rev_bits;
	assign icon_sel = row >= `LCDC_ROW_ICON;
	assign col_int  = mirror ? `LCDC_COL_LAST - col : col;
	// icon rows keep bit order; mirror and swap each flip graphic bytes once
	assign rev_bits = !icon_sel && (mirror ^ swap);
	assign wdata    = rev_bits ? lcdc_rev8(din) : din;
	// all-on wins over inversion
	assign dot      = disp_on && (all_on || (pix ^ invert));
	// disabled segments sit at ground level
	assign seg      = seg_on && seg_pix;
endmodule // lcdc_map

// File: lcdc_scan.sv
`include "lcdc_defines.svh"
module lcdc_scan #(
	parameter int LINES = 64
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 line_tick,
	input  wire lcdc_pkg::lcdc_line_t start,
	input  wire logic                 dir,
	input  wire logic                 line_alternation_enable,
	input  wire lcdc_pkg::lcdc_line_t ncode,
	output lcdc_pkg::lcdc_line_t      com_r,
	output lcdc_pkg::lcdc_line_t      line_r,
	output logic                      alt_r
);
	import lcdc_pkg::*;
	lcdc_line_t step_r;
	lcdc_line_t cnt_r;
	logic       last;
	// step wrap and direction math assume a 64-line panel
	if (LINES != 64) begin : g_lines_chk
		$error("scan needs 64 lines");
	end
	assign last = step_r == 6'(LINES - 1);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			step_r <= `LCDC_RST_LINE;
		end else if (line_tick) begin
			step_r <= last ? `LCDC_RST_LINE : step_r + 6'h01;
		end
	end
	// memory line and common index follow the step one clock later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			com_r  <= `LCDC_RST_LINE;
			line_r <= `LCDC_RST_LINE;
		end else begin
			com_r  <= dir ? 6'(LINES - 1) - step_r : step_r;
			line_r <= start + step_r;
		end
	end
	// code zero is undefined; it simply toggles every line here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= `LCDC_RST_LINE;
			alt_r <= 1'b0;
		end else if (line_tick) begin
			if (line_alternation_enable) begin
				cnt_r <= (cnt_r >= ncode) ? `LCDC_RST_LINE : cnt_r + 6'h01;
				alt_r <= (cnt_r >= ncode) ? !alt_r : alt_r;
			end else begin
				cnt_r <= `LCDC_RST_LINE;
				alt_r <= last ? !alt_r : alt_r;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_start_held;
		$stable(start) ##1 $stable(start);
	endsequence

	property p_line;
		@(posedge clk_sys) disable iff (!rst_n)
		s_start_held |-> line_r == 6'($past(start) + $past(step_r));
	endproperty
	a_line: assert property (p_line) else $error("memory line wrong");

	property p_dir;
		@(posedge clk_sys) disable iff (!rst_n)
		$stable(dir) |=> com_r == ($past(dir) ? 6'h3f - $past(step_r) : $past(step_r));
	endproperty
	a_dir: assert property (p_dir) else $error("scan direction wrong");

	property p_frame_alt;
		@(posedge clk_sys) disable iff (!rst_n)
		!line_alternation_enable && line_tick && step_r != 6'h3f |=> $stable(alt_r);
	endproperty
	a_frame_alt: assert property (p_frame_alt) else $error("polarity flipped mid frame");

	property p_line_alternation_enable;
		@(posedge clk_sys) disable iff (!rst_n)
		line_alternation_enable && line_tick && cnt_r < ncode |=> $stable(alt_r);
	endproperty
	a_line_alternation_enable: assert property (p_line_alternation_enable) else $error("polarity flipped early");
endmodule // lcdc_scan

// File: lcdc_regs.sv
// Behaviour
// - row address kept as 4+3 bit fields
// - rows 40h-42h select icon segment memory
// - high row field reads at 3h, d3 ignored
// - start line shown on first common output
// - following commons show incremented lines, mod 64
// - start fields read at 5h/4h, reset zero
// - alternation code k gives k+1 lines
// - line count used only when enabled
// - disabled: polarity reverses once per frame
// - display on bit, reads 8h, reset zero
// - all-on lights every dot, beats inversion
// - segments off drive ground level
// - scan direction bit reverses common order
// - mirror maps column to 0fh minus column
// - swap reverses graphic write bit order, unless mirror is also set
// - polarity bit selects which memory level lights
// - second control register reads 9h, reset zero
`include "lcdc_defines.svh"
module lcdc_regs (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// host port
	input  wire logic                 chip_sel_n,
	input  wire logic                 cmd_data_sel,
	input  wire logic                 ext_page_sel,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	input  wire lcdc_pkg::lcdc_byte_t host_din,
	output lcdc_pkg::lcdc_byte_t      host_dout_r,
	output logic                      host_dout_oe_r,
	// display memory write path
	input  wire lcdc_pkg::lcdc_nib_t  host_col,
	output logic                      mem_wr_r,
	output lcdc_pkg::lcdc_row_t       mem_row_r,
	output lcdc_pkg::lcdc_nib_t       mem_col_r,
	output lcdc_pkg::lcdc_byte_t      mem_wdata_r,
	output logic                      mem_icon_r,
	// scan and drive
	input  wire logic                 line_tick,
	input  wire logic                 pix_in,
	input  wire logic                 seg_pix_in,
	output lcdc_pkg::lcdc_line_t      com_index_r,
	output lcdc_pkg::lcdc_line_t      mem_line_r,
	output logic                      alt_polarity_r,
	output logic                      dot_on_r,
	output logic                      seg_out_r,
	// segment supply selects
	output logic                      int_ratio_sel_r,
	output logic                      ext_level_sel_r
);
	import lcdc_pkg::*;

	// ----------------------------------------
	// host decode
	// ----------------------------------------
	logic      sel;
	logic      reg_wr;
	logic      ram_wr;
	logic      reg_rd;
	lcdc_nib_t code;
	lcdc_nib_t val;
	assign sel    = !chip_sel_n;
	assign reg_wr = sel && cmd_data_sel && wr_stb;
	assign ram_wr = sel && !cmd_data_sel && wr_stb;
	assign reg_rd = sel && cmd_data_sel && rd_stb;
	assign code   = host_din[7:4];
	assign val    = host_din[3:0];

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	lcdc_nib_t  row_lo_r;
	logic [2:0] row_hi_r;
	lcdc_nib_t  start_lo_r;
	logic [1:0] start_hi_r;
	lcdc_nib_t  alt_lo_r;
	logic [1:0] alt_hi_r;
	lcdc_nib_t  disp1_r;
	logic [1:0] ext_r;
	lcdc_nib_t  disp2_r;
	lcdc_row_t  row;
	lcdc_line_t start_line_value;
	lcdc_line_t alternation_line_count;
	assign row                    = {row_hi_r, row_lo_r};
	assign start_line_value       = {start_hi_r, start_lo_r};
	assign alternation_line_count = {alt_hi_r, alt_lo_r};

	// low and high fields load separately; a row is only whole once both are in
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			row_lo_r <= `LCDC_RST_NIB;
			row_hi_r <= 3'h0;
		end else if (reg_wr && !ext_page_sel) begin
			if (code == `LCDC_OFS_ROW_LO) begin
				row_lo_r <= val;
			end
			if (code == `LCDC_OFS_ROW_HI) begin
				row_hi_r <= val[2:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_lo_r <= `LCDC_RST_NIB;
			start_hi_r <= 2'h0;
		end else if (reg_wr && !ext_page_sel) begin
			if (code == `LCDC_OFS_START_LO) begin
				start_lo_r <= val;
			end
			if (code == `LCDC_OFS_START_HI) begin
				start_hi_r <= val[1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alt_lo_r <= `LCDC_RST_NIB;
			alt_hi_r <= 2'h0;
		end else if (reg_wr && !ext_page_sel) begin
			if (code == `LCDC_OFS_ALT_LO) begin
				alt_lo_r <= val;
			end
			if (code == `LCDC_OFS_ALT_HI) begin
				alt_hi_r <= val[1:0];
			end
		end
	end

	// code 8h reaches two registers; the page bit picks one
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			disp1_r <= `LCDC_RST_NIB;
			ext_r   <= 2'h0;
			disp2_r <= `LCDC_RST_NIB;
		end else if (reg_wr) begin
			if (code == `LCDC_OFS_DISP1 && !ext_page_sel) begin
				disp1_r <= val;
			end
			if (code == `LCDC_OFS_DISP1 && ext_page_sel) begin
				ext_r <= val[1:0];
			end
			if (code == `LCDC_OFS_DISP2 && !ext_page_sel) begin
				disp2_r <= val;
			end
		end
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	lcdc_nib_t rd_val;
	always_comb begin
		rd_val = `LCDC_RST_NIB;
		if (ext_page_sel) begin
			if (val == `LCDC_OFS_DISP1) begin
				rd_val = {2'h0, ext_r};
			end
		end else begin
			case (val)
				`LCDC_OFS_ROW_LO:   rd_val = row_lo_r;
				`LCDC_OFS_ROW_HI:   rd_val = {1'b0, row_hi_r};
				`LCDC_OFS_START_LO: rd_val = start_lo_r;
				`LCDC_OFS_START_HI: rd_val = {2'h0, start_hi_r};
				`LCDC_OFS_ALT_LO:   rd_val = alt_lo_r;
				`LCDC_OFS_ALT_HI:   rd_val = {2'h0, alt_hi_r};
				`LCDC_OFS_DISP1:    rd_val = disp1_r;
				`LCDC_OFS_DISP2:    rd_val = disp2_r;
				default:            rd_val = `LCDC_RST_NIB;
			endcase
		end
	end

	// the read address rides on d3..d0; data comes back one clock later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			host_dout_r    <= 8'h00;
			host_dout_oe_r <= 1'b0;
		end else begin
			host_dout_oe_r <= reg_rd;
			if (reg_rd) begin
				host_dout_r <= {4'h0, rd_val};
			end
		end
	end

	// ----------------------------------------
	// memory write mapping and dot drive
	// ----------------------------------------
	lcdc_byte_t map_wdata;
	lcdc_nib_t  map_col;
	logic       map_icon;
	logic       map_dot;
	logic       map_seg;
	lcdc_map u_map (
		.din     (host_din),
		.col     (host_col),
		.row     (row),
		.mirror  (disp2_r[`LCDC_B_REF]),
		.swap    (disp2_r[`LCDC_B_SWAP]),
		.wdata   (map_wdata),
		.col_int (map_col),
		.icon_sel(map_icon),
		.pix     (pix_in),
		.seg_pix (seg_pix_in),
		.disp_on (disp1_r[`LCDC_B_DISP_ON]),
		.all_on  (disp1_r[`LCDC_B_ALL_ON]),
		.invert  (disp2_r[`LCDC_B_REV]),
		.seg_on  (disp1_r[`LCDC_B_SEG_ON]),
		.dot     (map_dot),
		.seg     (map_seg)
	);

	// row range beyond 42h is the host's problem; no clamp here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_wr_r    <= 1'b0;
			mem_row_r   <= 7'h00;
			mem_col_r   <= `LCDC_RST_NIB;
			mem_wdata_r <= 8'h00;
			mem_icon_r  <= 1'b0;
		end else begin
			mem_wr_r <= ram_wr;
			if (ram_wr) begin
				mem_row_r   <= row;
				mem_col_r   <= map_col;
				mem_wdata_r <= map_wdata;
				mem_icon_r  <= map_icon;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dot_on_r        <= 1'b0;
			seg_out_r       <= 1'b0;
			int_ratio_sel_r <= 1'b0;
			ext_level_sel_r <= 1'b0;
		end else begin
			dot_on_r        <= map_dot;
			seg_out_r       <= map_seg;
			int_ratio_sel_r <= ext_r[`LCDC_B_IR];
			ext_level_sel_r <= ext_r[`LCDC_B_ER];
		end
	end

	// ----------------------------------------
	// common scan
	// ----------------------------------------
	lcdc_scan #(
		.LINES(64)
	) u_scan (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.line_tick(line_tick),
		.start    (start_line_value),
		.dir      (disp1_r[`LCDC_B_SHIFT]),
		.line_alternation_enable     (disp2_r[`LCDC_B_LINE_ALTERNATION_ENABLE]),
		.ncode    (alternation_line_count),
		.com_r    (com_index_r),
		.line_r   (mem_line_r),
		.alt_r    (alt_polarity_r)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_wr(lcdc_nib_t c);
		reg_wr && !ext_page_sel && code == c;
	endsequence
	sequence s_rd(lcdc_nib_t a);
		reg_rd && !ext_page_sel && val == a;
	endsequence

	property p_row_lo;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wr(`LCDC_OFS_ROW_LO) |=> row_lo_r == $past(val) && row_hi_r == $past(row_hi_r);
	endproperty
	a_row_lo: assert property (p_row_lo) else $error("row low write wrong");

	property p_row_hi_rd;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wr(`LCDC_OFS_ROW_HI) ##2 s_rd(`LCDC_OFS_ROW_HI)
			|=> host_dout_r == {5'h00, $past(host_din[2:0], 3)} && !host_dout_r[3];
	endproperty
	a_row_hi_rd: assert property (p_row_hi_rd) else $error("row high readback wrong");

	property p_icon;
		@(posedge clk_sys) disable iff (!rst_n)
		ram_wr |=> mem_wr_r && mem_icon_r == (mem_row_r >= `LCDC_ROW_ICON);
	endproperty
	a_icon: assert property (p_icon) else $error("icon select wrong");

	property p_start_rd;
		@(posedge clk_sys) disable iff (!rst_n)
		s_rd(`LCDC_OFS_START_HI) |=> host_dout_oe_r && host_dout_r == {6'h00, $past(start_hi_r)};
	endproperty
	a_start_rd: assert property (p_start_rd) else $error("start high readback wrong");

	property p_all_on;
		@(posedge clk_sys) disable iff (!rst_n)
		disp1_r[`LCDC_B_ALL_ON] && disp1_r[`LCDC_B_DISP_ON] |=> dot_on_r;
	endproperty
	a_all_on: assert property (p_all_on) else $error("all-on dot dark");

	property p_polarity;
		@(posedge clk_sys) disable iff (!rst_n)
		disp1_r[`LCDC_B_DISP_ON] && !disp1_r[`LCDC_B_ALL_ON]
			|=> dot_on_r == ($past(pix_in) ^ $past(disp2_r[`LCDC_B_REV]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("dot polarity wrong");

	property p_disp_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!disp1_r[`LCDC_B_DISP_ON] |=> !dot_on_r;
	endproperty
	a_disp_off: assert property (p_disp_off) else $error("dot lit with display off");

	property p_seg_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!disp1_r[`LCDC_B_SEG_ON] |=> !seg_out_r;
	endproperty
	a_seg_off: assert property (p_seg_off) else $error("segment driven while off");

	property p_swap;
		@(posedge clk_sys) disable iff (!rst_n)
		ram_wr && !map_icon && !disp2_r[`LCDC_B_REF] && disp2_r[`LCDC_B_SWAP]
			|=> mem_wdata_r == lcdc_rev8($past(host_din));
	endproperty
	a_swap: assert property (p_swap) else $error("swap byte wrong");

	property p_mirror;
		@(posedge clk_sys) disable iff (!rst_n)
		ram_wr && disp2_r[`LCDC_B_REF] |=> mem_col_r == 4'hf - $past(host_col);
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirrored column wrong");

	property p_disp2_rd;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wr(`LCDC_OFS_DISP2) ##2 s_rd(`LCDC_OFS_DISP2)
			|=> host_dout_r == {4'h0, $past(host_din[3:0], 3)};
	endproperty
	a_disp2_rd: assert property (p_disp2_rd) else $error("control 2 readback wrong");
endmodule // lcdc_regs

// File: lcdc_host_model.sv
module lcdc_host_model
	import lcdc_pkg::*;
(
	// clock
	input  wire logic                 clk_sys,
	// host bus
	output logic                      chip_sel_n,
	output logic                      cmd_data_sel,
	output logic                      ext_page_sel,
	output logic                      wr_stb,
	output logic                      rd_stb,
	output lcdc_pkg::lcdc_byte_t      host_din,
	input  wire lcdc_pkg::lcdc_byte_t host_dout_r,
	input  wire logic                 host_dout_oe_r
);
	import lcdc_pkg::*;

	initial begin
		chip_sel_n   = 1'b1;
		cmd_data_sel = 1'b0;
		ext_page_sel = 1'b0;
		wr_stb       = 1'b0;
		rd_stb       = 1'b0;
		host_din     = 8'h5a;
	end

	// ----------------------------------------
	// one bus cycle: taken at the next edge, answer read just after that same edge
	// ----------------------------------------
	task automatic cycle(input logic cs_n, input logic rs, input logic page, input logic wr,
			input lcdc_byte_t d, output logic oe, output lcdc_byte_t q);
		@(posedge clk_sys);
		#1;
		chip_sel_n   = cs_n;
		cmd_data_sel = rs;
		ext_page_sel = page;
		wr_stb       = wr;
		rd_stb       = !wr;
		host_din     = d;
		@(posedge clk_sys);
		#1;
		oe           = host_dout_oe_r;
		q            = host_dout_r;
		wr_stb       = 1'b0;
		rd_stb       = 1'b0;
		chip_sel_n   = 1'b1;
		// released bus: inverted so a stale value never passes as the last one
		host_din     = ~d;
	endtask
endmodule // lcdc_host_model

// File: tb_lcd_display_control_registers.sv
module tb_lcd_display_control_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import lcdc_pkg::*;

	typedef struct packed {logic pg; logic [3:0] code; logic [3:0] val; logic [3:0] exp;} lcdc_reg_case_t;
	typedef struct packed {logic line_alternation_enable; logic [5:0] code; logic [7:0] ticks; logic [7:0] tog;} lcdc_alt_case_t;

	localparam lcdc_reg_case_t REG_CASES [10] = '{
		'{1'b0, 4'h2, 4'hd, 4'hd}, '{1'b0, 4'h3, 4'ha, 4'h2}, '{1'b0, 4'h4, 4'ha, 4'ha},
		'{1'b0, 4'h5, 4'hf, 4'h3}, '{1'b0, 4'h6, 4'h5, 4'h5}, '{1'b0, 4'h7, 4'he, 4'h2},
		'{1'b1, 4'h8, 4'he, 4'h2}, '{1'b0, 4'h8, 4'hf, 4'hf}, '{1'b0, 4'h9, 4'hc, 4'hc},
		'{1'b1, 4'h9, 4'hf, 4'h0}};
	localparam lcdc_alt_case_t ALT_CASES [4] = '{
		'{1'b1, 6'h02, 8'h0c, 8'h04}, '{1'b1, 6'h01, 8'h08, 8'h04},
		'{1'b1, 6'h3f, 8'h80, 8'h02}, '{1'b0, 6'h05, 8'h80, 8'h02}};

	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic chip_sel_n, cmd_data_sel, ext_page_sel, wr_stb, rd_stb, host_dout_oe_r, mem_wr_r;
	logic line_tick = 1'b0;
	logic pix_in = 1'b0;
	logic seg_pix_in = 1'b0;
	logic mem_icon_r, alt_polarity_r, dot_on_r, seg_out_r, alt_q, oe;
	logic int_ratio_sel_r, ext_level_sel_r;
	lcdc_byte_t host_din, host_dout_r, mem_wdata_r, q;
	lcdc_nib_t host_col = 4'h0;
	lcdc_nib_t mem_col_r;
	lcdc_row_t mem_row_r;
	lcdc_line_t com_index_r, mem_line_r;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	int toggles = 0;

	always #5 clk_sys = ~clk_sys;

	lcdc_host_model host (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .cmd_data_sel(cmd_data_sel),
		.ext_page_sel(ext_page_sel), .wr_stb(wr_stb), .rd_stb(rd_stb), .host_din(host_din),
		.host_dout_r(host_dout_r), .host_dout_oe_r(host_dout_oe_r));

	lcdc_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .chip_sel_n(chip_sel_n),
		.cmd_data_sel(cmd_data_sel), .ext_page_sel(ext_page_sel), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .host_din(host_din), .host_dout_r(host_dout_r),
		.host_dout_oe_r(host_dout_oe_r), .host_col(host_col), .mem_wr_r(mem_wr_r),
		.mem_row_r(mem_row_r), .mem_col_r(mem_col_r), .mem_wdata_r(mem_wdata_r),
		.mem_icon_r(mem_icon_r), .line_tick(line_tick), .pix_in(pix_in),
		.seg_pix_in(seg_pix_in), .com_index_r(com_index_r), .mem_line_r(mem_line_r),
		.alt_polarity_r(alt_polarity_r), .dot_on_r(dot_on_r), .seg_out_r(seg_out_r),
		.int_ratio_sel_r(int_ratio_sel_r), .ext_level_sel_r(ext_level_sel_r));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hang guard: whole run needs well under 10000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		alt_q <= alt_polarity_r;
		if (alt_q !== alt_polarity_r) begin
			toggles++;
		end
		if (cycles == 30000) begin
			err_total++;
			summarize();
		end
	end

	// ----------------------------------------
	// bus helpers
	// ----------------------------------------
	task automatic wr(input logic pg, input logic [3:0] code, input logic [3:0] val);
		host.cycle(1'b0, 1'b1, pg, 1'b1, {code, val}, oe, q);
	endtask

	task automatic rd(input logic pg, input logic [3:0] adr, input logic [3:0] exp);
		host.cycle(1'b0, 1'b1, pg, 1'b0, {4'h0, adr}, oe, q);
		chk("read strobe", 8'h01, {7'h0, oe});
		chk("read data", {4'h0, exp}, q);
	endtask

	task automatic ram(input lcdc_byte_t d, input lcdc_nib_t col, input lcdc_byte_t ed,
			input lcdc_nib_t ec, input logic ei, input lcdc_row_t er);
		host_col = col;
		host.cycle(1'b0, 1'b0, 1'b0, 1'b1, d, oe, q);
		chk("ram strobe", 8'h01, {7'h0, mem_wr_r});
		chk("ram data", ed, mem_wdata_r);
		chk("ram column", {4'h0, ec}, {4'h0, mem_col_r});
		chk("ram icon", {7'h0, ei}, {7'h0, mem_icon_r});
		chk("ram row", {1'b0, er}, {1'b0, mem_row_r});
	endtask

	task automatic tick(input int n);
		@(posedge clk_sys);
		#1;
		line_tick = 1'b1;
		repeat (n) @(posedge clk_sys);
		#1;
		line_tick = 1'b0;
	endtask

	task automatic zero_check();
		for (int a = 2; a < 10; a++) begin
			rd(1'b0, a[3:0], 4'h0);
		end
		rd(1'b1, 4'h8, 4'h0);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		zero_check();
		foreach (REG_CASES[i]) begin
			wr(REG_CASES[i].pg, REG_CASES[i].code, REG_CASES[i].val);
			rd(REG_CASES[i].pg, REG_CASES[i].code, REG_CASES[i].exp);
		end
		// segment supply picks were set before the segments were switched on
		chk("ratio select", 8'h00, {7'h0, int_ratio_sel_r});
		chk("level select", 8'h01, {7'h0, ext_level_sel_r});
		rd(1'b0, 4'h8, 4'hf);
		rd(1'b0, 4'hc, 4'h0);
		host.cycle(1'b1, 1'b1, 1'b0, 1'b1, 8'h9f, oe, q);
		rd(1'b0, 4'h9, 4'hc);
		// row 3fh, low field first
		wr(1'b0, 4'h2, 4'hf);
		wr(1'b0, 4'h3, 4'h3);
		wr(1'b0, 4'h9, 4'h0);
		ram(8'h01, 4'h3, 8'h01, 4'h3, 1'b0, 7'h3f);
		wr(1'b0, 4'h9, 4'h2);
		ram(8'h01, 4'h3, 8'h80, 4'h3, 1'b0, 7'h3f);
		wr(1'b0, 4'h9, 4'h1);
		ram(8'h03, 4'h3, 8'hc0, 4'hc, 1'b0, 7'h3f);
		wr(1'b0, 4'h9, 4'h3);
		ram(8'h03, 4'h3, 8'h03, 4'hc, 1'b0, 7'h3f);
		wr(1'b0, 4'h2, 4'h0);
		wr(1'b0, 4'h3, 4'h4);
		wr(1'b0, 4'h9, 4'h2);
		ram(8'h01, 4'hf, 8'h01, 4'hf, 1'b1, 7'h40);
		wr(1'b0, 4'h2, 4'h2);
		ram(8'h01, 4'h0, 8'h01, 4'h0, 1'b1, 7'h42);
		// mirrored icon column: host sends 0fh for column 0, bit order kept
		wr(1'b0, 4'h9, 4'h1);
		ram(8'h01, 4'hf, 8'h01, 4'h0, 1'b1, 7'h42);
		// scan order, start line 5 wraps through 63
		wr(1'b0, 4'h4, 4'h5);
		wr(1'b0, 4'h5, 4'h0);
		for (int i = 0; i < 140; i++) begin
			wr(1'b0, 4'h8, (i < 70) ? 4'h0 : 4'h8);
			tick(1);
			repeat (2) @(posedge clk_sys);
			#1;
			chk("line", {2'b0, (i < 70) ? 6'(com_index_r + 6'd5) : 6'(6'd63 - com_index_r + 6'd5)},
				{2'b0, mem_line_r});
		end
		foreach (ALT_CASES[i]) begin
			wr(1'b0, 4'h6, ALT_CASES[i].code[3:0]);
			wr(1'b0, 4'h7, {2'b0, ALT_CASES[i].code[5:4]});
			wr(1'b0, 4'h9, {1'b0, ALT_CASES[i].line_alternation_enable, 2'b0});
			tick(64);
			// step off the edge so the counter clear never races the edge monitor
			repeat (3) @(posedge clk_sys);
			#1;
			toggles = 0;
			tick(int'(ALT_CASES[i].ticks));
			repeat (3) @(posedge clk_sys);
			#1;
			chk("alternation toggles", ALT_CASES[i].tog, 8'(toggles));
		end
		// dot drive over every control combination
		for (int i = 0; i < 32; i++) begin
			wr(1'b0, 4'h8, {1'b0, i[3], i[1], i[0]});
			wr(1'b0, 4'h9, {i[2], 3'b0});
			pix_in = i[4];
			seg_pix_in = i[4];
			repeat (2) @(posedge clk_sys);
			#1;
			chk("dot", {7'h0, i[0] & (i[1] | (i[4] ^ i[2]))}, {7'h0, dot_on_r});
			chk("segment", {7'h0, i[3] & i[4]}, {7'h0, seg_out_r});
		end
		// reset in mid-run clears every field again
		rst_n = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		zero_check();
		summarize();
	end
endmodule // tb_lcd_display_control_registers
